// ==== hdl/msp_pkg.sv ====
`default_nettype none
package msp_pkg;
    // ***********************************************
    // widths
    // ***********************************************
    localparam int RESULT_W = 18;
    localparam int CH_W     = 2;
    localparam int ADDR_W   = 5;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS  = 650;
    // longest time: rounded down, at least one cycle
    localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_CYCLES     = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int CNT_W           = 8;

    // ***********************************************
    // register map (byte addresses)
    // ***********************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_RESULT   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

    // ***********************************************
    // fields
    // ***********************************************
    localparam int CTRL_CONV_EN_BIT = 0;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_AUTO_BIT    = 1;
    localparam int STAT_CH_LSB      = 4;
    localparam int IRQ_DONE_BIT     = 0;
    localparam int IRQ_WRAP_BIT     = 1;
    localparam int IRQ_W            = 2;

    localparam logic              CTRL_RESET     = 1'b1;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET = 2'h0;
    localparam logic [CH_W-1:0]   CH_ZERO        = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        MSP_IDLE,
        MSP_CONVERT
    } msp_conv_state_t;
endpackage
`default_nettype wire

// ==== hdl/msp_mux_seq.sv ====
`default_nettype none
module msp_mux_seq (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     auto_mode,
    input  wire logic                     count_sel_high,
    input  wire logic                     count_sel_low,
    input  wire logic                     sequence_reset_pin,
    input  wire logic                     mux_step_clock,
    output var  logic [msp_pkg::CH_W-1:0] ch_sel_ff,
    output var  logic                     wrap_ff
);
    // ***********************************************
    // step edge detect
    // ***********************************************
    logic                     step_prev_ff;
    logic                     step_rise;
    logic [msp_pkg::CH_W-1:0] count_sel;
    logic [msp_pkg::CH_W-1:0] nxt_ch;
    logic                     nxt_wrap;

    assign step_rise = mux_step_clock && !step_prev_ff;
    assign count_sel = {count_sel_high, count_sel_low};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_prev_ff <= 1'b0;
        end else begin
            step_prev_ff <= mux_step_clock;
        end
    end

    // ***********************************************
    // channel selection
    // ***********************************************
    always_comb begin
        nxt_ch   = ch_sel_ff;
        nxt_wrap = 1'b0;
        if (step_rise) begin
            if (!auto_mode) begin
                nxt_ch = count_sel;
            end else if (sequence_reset_pin) begin
                nxt_ch = msp_pkg::CH_ZERO;
            end else if (ch_sel_ff == count_sel) begin
                nxt_ch   = msp_pkg::CH_ZERO;
                nxt_wrap = 1'b1;
            end else begin
                nxt_ch = ch_sel_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_sel_ff <= msp_pkg::CH_ZERO;
            wrap_ff   <= 1'b0;
        end else begin
            ch_sel_ff <= nxt_ch;
            wrap_ff   <= nxt_wrap;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/msp_top.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module msp_top #(
    parameter int RESULT_W = msp_pkg::RESULT_W
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // converter pins
    input  wire logic                       auto_mode,
    input  wire logic                       count_sel_high,
    input  wire logic                       count_sel_low,
    input  wire logic                       sequence_reset_pin,
    input  wire logic                       mux_step_clock,
    input  wire logic                       convert_start_n,
    input  wire logic                       cs_n,
    input  wire logic                       rd_n,
    input  wire logic                       byte_select,
    input  wire logic                       wide_word_select,
    input  wire logic [RESULT_W-1:0]        sample_code,
    output var  logic [RESULT_W-1:0]        db_out_ff,
    output var  logic                       db_oe_ff,
    output var  logic                       busy_ff,
    output var  logic [msp_pkg::CH_W-1:0]   ch_sel_ff,
    output var  logic                       irq_ff,
    // axi4-lite slave
    input  wire logic [msp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [msp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    // ***********************************************
    // functions
    // ***********************************************
    // lane arrangement for the parallel read-out
    function automatic logic [RESULT_W-1:0] lane_map(
        input logic [RESULT_W-1:0] r,
        input logic                bsel,
        input logic                wsel
    );
        logic [RESULT_W-1:0] v;
        v = '1;
        if (!bsel && !wsel) begin
            v = r;
        end else if (bsel && !wsel) begin
            v[17:10] = r[9:2];
        end else if (!bsel && wsel) begin
            v[3:2] = r[1:0];
        end else begin
            v[11:10] = r[1:0];
        end
        return v;
    endfunction

    function automatic logic addr_known(input logic [msp_pkg::ADDR_W-1:0] a);
        return (a == msp_pkg::OFS_CTRL) || (a == msp_pkg::OFS_STATUS) ||
               (a == msp_pkg::OFS_RESULT) || (a == msp_pkg::OFS_IRQ_STAT) ||
               (a == msp_pkg::OFS_IRQ_MASK);
    endfunction

    // ***********************************************
    // multiplexer sequencer
    // ***********************************************
    logic wrap_ev;

    msp_mux_seq msp_mux_seq_inst (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .auto_mode          (auto_mode),
        .count_sel_high     (count_sel_high),
        .count_sel_low      (count_sel_low),
        .sequence_reset_pin (sequence_reset_pin),
        .mux_step_clock     (mux_step_clock),
        .ch_sel_ff          (ch_sel_ff),
        .wrap_ff            (wrap_ev)
    );

    // ***********************************************
    // conversion
    // ***********************************************
    msp_pkg::msp_conv_state_t state_ff;
    logic                     start_prev_ff;
    logic                     start_fall;
    logic [msp_pkg::CNT_W-1:0] cnt_ff;
    logic [RESULT_W-1:0]      sample_ff;
    logic [RESULT_W-1:0]      result_ff;
    logic                     done_ev;
    logic                     conv_en_ff;

    assign start_fall = start_prev_ff && !convert_start_n;
    assign done_ev    = (state_ff == msp_pkg::MSP_CONVERT) &&
                        (cnt_ff == msp_pkg::CNT_W'(msp_pkg::CONV_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_prev_ff <= 1'b1;
        end else begin
            start_prev_ff <= convert_start_n;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= msp_pkg::MSP_IDLE;
            cnt_ff    <= '0;
            busy_ff   <= 1'b0;
            sample_ff <= '0;
            result_ff <= '0;
        end else begin
            unique case (state_ff)
                msp_pkg::MSP_IDLE: begin
                    cnt_ff <= '0;
                    if (start_fall && conv_en_ff) begin
                        sample_ff <= sample_code;
                        busy_ff   <= 1'b1;
                        state_ff  <= msp_pkg::MSP_CONVERT;
                    end
                end
                msp_pkg::MSP_CONVERT: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (done_ev) begin
                        result_ff <= sample_ff;
                        busy_ff   <= 1'b0;
                        state_ff  <= msp_pkg::MSP_IDLE;
                    end
                end
            endcase
        end
    end

    // ***********************************************
    // parallel read-out
    // ***********************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            db_oe_ff  <= 1'b0;
            db_out_ff <= '0;
        end else begin
            db_oe_ff  <= !cs_n && !rd_n;
            db_out_ff <= lane_map(result_ff, byte_select, wide_word_select);
        end
    end

    // ***********************************************
    // axi4-lite write channel
    // ***********************************************
    logic                       aw_got_ff;
    logic                       w_got_ff;
    logic [msp_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0]                wdata_ff;
    logic [3:0]                 wstrb_ff;
    logic                       wr_fire;

    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= '0;
            wdata_ff      <= '0;
            wstrb_ff      <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= msp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff     <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_ff && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff     <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_got_ff && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(awaddr_ff) ? msp_pkg::RESP_OKAY
                                                      : msp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
            end
        end
    end

    // ***********************************************
    // registers and interrupt
    // ***********************************************
    logic [msp_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [msp_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [msp_pkg::IRQ_W-1:0] irq_set;
    logic [msp_pkg::IRQ_W-1:0] irq_clr;
    logic                      wr_lane0;

    assign wr_lane0 = wr_fire && wstrb_ff[0];
    always_comb begin
        irq_set = '0;
        irq_set[msp_pkg::IRQ_DONE_BIT] = done_ev;
        irq_set[msp_pkg::IRQ_WRAP_BIT] = wrap_ev;
        irq_clr = '0;
        if (wr_lane0 && (awaddr_ff == msp_pkg::OFS_IRQ_STAT)) begin
            irq_clr = wdata_ff[msp_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_en_ff  <= msp_pkg::CTRL_RESET;
            irq_mask_ff <= msp_pkg::IRQ_MASK_RESET;
        end else if (wr_lane0) begin
            if (awaddr_ff == msp_pkg::OFS_CTRL) begin
                conv_en_ff <= wdata_ff[msp_pkg::CTRL_CONV_EN_BIT];
            end
            if (awaddr_ff == msp_pkg::OFS_IRQ_MASK) begin
                irq_mask_ff <= wdata_ff[msp_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            // set wins over a simultaneous write-one clear
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff      <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
        end
    end

    // ***********************************************
    // axi4-lite read channel
    // ***********************************************
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        unique case (s_axi_araddr)
            msp_pkg::OFS_CTRL: begin
                rd_word[msp_pkg::CTRL_CONV_EN_BIT] = conv_en_ff;
            end
            msp_pkg::OFS_STATUS: begin
                rd_word[msp_pkg::STAT_BUSY_BIT] = busy_ff;
                rd_word[msp_pkg::STAT_AUTO_BIT] = auto_mode;
                rd_word[msp_pkg::STAT_CH_LSB +: msp_pkg::CH_W] = ch_sel_ff;
            end
            msp_pkg::OFS_RESULT: begin
                rd_word[RESULT_W-1:0] = result_ff;
            end
            msp_pkg::OFS_IRQ_STAT: begin
                rd_word[msp_pkg::IRQ_W-1:0] = irq_stat_ff;
            end
            msp_pkg::OFS_IRQ_MASK: begin
                rd_word[msp_pkg::IRQ_W-1:0] = irq_mask_ff;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= msp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= addr_known(s_axi_araddr) ? msp_pkg::RESP_OKAY
                                                          : msp_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/msp_monitor.sv ====
`default_nettype none
module msp_monitor #(
    parameter int RESULT_W = msp_pkg::RESULT_W
) (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     auto_mode,
    input wire logic                     count_sel_high,
    input wire logic                     count_sel_low,
    input wire logic                     sequence_reset_pin,
    input wire logic                     mux_step_clock,
    input wire logic                     convert_start_n,
    input wire logic                     cs_n,
    input wire logic                     rd_n,
    input wire logic                     byte_select,
    input wire logic                     wide_word_select,
    input wire logic [RESULT_W-1:0]      sample_code,
    input wire logic [RESULT_W-1:0]      db_out_ff,
    input wire logic                     db_oe_ff,
    input wire logic                     busy_ff,
    input wire logic [msp_pkg::CH_W-1:0] ch_sel_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // busy length counter and captured sample
    // ****************************************
    logic [7:0]          cnt_ff;
    logic [RESULT_W-1:0] cap_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy_ff) cnt_ff <= 8'h00;
        else cnt_ff <= cnt_ff + 8'h01;
    end
    always_ff @(posedge aclk) begin
        if ($fell(convert_start_n) && !busy_ff) cap_ff <= sample_code;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // checks
    // ****************************************
    chk_bus_float: assert property ((cs_n || rd_n) |=> !db_oe_ff)
        else $error("data bus driven without read");
    chk_bus_drive: assert property ((!cs_n && !rd_n) |=> db_oe_ff)
        else $error("data bus not driven during read");
    chk_busy_start: assert property ($rose(busy_ff) |-> $past(convert_start_n, 2) && !$past(convert_start_n))
        else $error("busy rose without start edge");
    chk_conv_time: assert property ($fell(busy_ff) && $past(aresetn) |-> cnt_ff == 8'(msp_pkg::CONV_CYCLES))
        else $error("conversion length wrong");
    chk_busy_max: assert property (busy_ff |-> cnt_ff < 8'(msp_pkg::CONV_CYCLES))
        else $error("busy held too long");
    chk_full_result: assert property ($fell(busy_ff) && !byte_select && !wide_word_select
        |=> db_out_ff == cap_ff) else $error("result lanes wrong");
    chk_byte_lanes: assert property (byte_select && !wide_word_select
        |=> db_out_ff[9:0] == 10'h3ff) else $error("byte lanes not filled");
    chk_wide_lanes: assert property (wide_word_select && !byte_select
        |=> db_out_ff[17:4] == 14'h3fff && db_out_ff[1:0] == 2'h3)
        else $error("wide lanes not filled");
    chk_seq_reset: assert property ($rose(mux_step_clock) && auto_mode && sequence_reset_pin
        |=> ch_sel_ff == 2'h0) else $error("sequence reset missed");
    chk_seq_advance: assert property ($rose(mux_step_clock) && auto_mode
        && !sequence_reset_pin && ch_sel_ff != {count_sel_high, count_sel_low}
        |=> ch_sel_ff == $past(ch_sel_ff) + 2'h1) else $error("channel did not advance");
    chk_seq_wrap: assert property ($rose(mux_step_clock) && auto_mode
        && !sequence_reset_pin && ch_sel_ff == {count_sel_high, count_sel_low}
        |=> ch_sel_ff == 2'h0) else $error("channel did not wrap");
    chk_manual_addr: assert property ($rose(mux_step_clock) && !auto_mode
        |=> ch_sel_ff == $past({count_sel_high, count_sel_low}))
        else $error("manual address not applied");
    chk_ch_init: assert property ($rose(aresetn) |-> ch_sel_ff == 2'h0)
        else $error("channel not zero after reset");
endmodule
bind msp_top msp_monitor #(.RESULT_W(RESULT_W)) msp_monitor_inst (
    .aclk, .aresetn, .auto_mode, .count_sel_high, .count_sel_low, .sequence_reset_pin,
    .mux_step_clock, .convert_start_n, .cs_n, .rd_n, .byte_select, .wide_word_select,
    .sample_code, .db_out_ff, .db_oe_ff, .busy_ff, .ch_sel_ff
);
`default_nettype wire

// ==== verif/msp_host_model.sv ====
`default_nettype none
module msp_host_model (
    input  wire logic        aclk,
    input  wire logic        busy_ff,
    input  wire logic [17:0] db_out_ff,
    input  wire logic        db_oe_ff,
    output var  logic        convert_start_n,
    output var  logic        cs_n,
    output var  logic        rd_n,
    output var  logic        byte_select,
    output var  logic        wide_word_select,
    output wire logic        mux_step_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic step_lvl;
    logic tie_busy;
    time  t_start;
    assign mux_step_clock = tie_busy ? busy_ff : step_lvl;
    initial begin
        {convert_start_n, cs_n, rd_n} = 3'h7;
        {byte_select, wide_word_select, step_lvl, tie_busy} = 4'h0;
        t_start = 0;
    end
    task automatic pins(input logic c, input logic r);
        cs_n <= c;
        rd_n <= r;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task automatic read(input logic b, input logic w, output logic [17:0] d);
        while ($time < t_start + 40) @(posedge aclk);
        byte_select <= b;
        wide_word_select <= w;
        pins(1'b0, 1'b0);
        // a released bus reads back as the inverse of what the lanes hold
        d = db_oe_ff ? db_out_ff : ~db_out_ff;
        pins(1'b1, 1'b1);
    endtask
    task automatic convert();
        repeat (6) @(posedge aclk);
        convert_start_n <= 1'b0;
        t_start = $time;
        @(posedge aclk);
        convert_start_n <= 1'b1;
    endtask
    task automatic step();
        step_lvl <= 1'b1;
        repeat (2) @(posedge aclk);
        step_lvl <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verif/msp_top_tb.sv ====
`default_nettype none
module msp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, auto_mode = 1'b1;
    logic        count_sel_high = 1'b0, count_sel_low = 1'b0, sequence_reset_pin = 1'b0;
    logic [17:0] sample_code = 18'h00000;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        convert_start_n, cs_n, rd_n, byte_select, wide_word_select, mux_step_clock;
    logic [17:0] db_out_ff;
    logic        db_oe_ff, busy_ff, irq_ff, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  ch_sel_ff, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, v;
    logic [1:0]  r;
    int          n, fails = 0, samples_checked = 0;
    msp_top msp_top_inst (
        .aclk, .aresetn, .auto_mode, .count_sel_high, .count_sel_low, .sequence_reset_pin,
        .mux_step_clock, .convert_start_n, .cs_n, .rd_n, .byte_select, .wide_word_select,
        .sample_code, .db_out_ff, .db_oe_ff, .busy_ff, .ch_sel_ff, .irq_ff, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    msp_host_model msp_host_model_inst (
        .aclk, .busy_ff, .db_out_ff, .db_oe_ff, .convert_start_n, .cs_n, .rd_n,
        .byte_select, .wide_word_select, .mux_step_clock
    );
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        logic aw = 1'b1, w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] a);
        logic ar = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            ar = ar && !s_axi_arready;
            s_axi_arvalid <= ar;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task automatic conv_run();
        msp_host_model_inst.convert();
        #1;
        n = 0;
        while (busy_ff === 1'b1 && n < 200) begin
            @(posedge aclk);
            #1;
            n++;
        end
    endtask
    function automatic logic [17:0] lanes(input logic [17:0] c, input logic b, input logic w);
        case ({b, w})
            2'b00: lanes = c;
            2'b10: lanes = {c[9:2], 10'h3ff};
            2'b01: lanes = {14'h3fff, c[1:0], 2'h3};
            default: lanes = {6'h3f, c[1:0], 10'h3ff};
        endcase
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        chk(32'(ch_sel_ff), 32'h0);
        axi_rd(msp_pkg::OFS_CTRL);
        chk(v, 32'h1);
        axi_rd(msp_pkg::OFS_IRQ_MASK);
        chk(v, 32'h0);
        axi_rd(5'h14);
        chk(32'(r), 32'(msp_pkg::RESP_SLVERR));
        axi_wr(5'h18, 32'h1);
        chk(32'(r), 32'(msp_pkg::RESP_SLVERR));
        axi_wr(msp_pkg::OFS_STATUS, 32'hffffffff);
        axi_rd(msp_pkg::OFS_STATUS);
        chk(v, 32'h2);
        axi_wr(msp_pkg::OFS_CTRL, 32'h0);
        conv_run();
        chk(n, 0);
        axi_wr(msp_pkg::OFS_CTRL, 32'h1);
    endtask
    task automatic t_bus_float();
        for (int k = 0; k < 4; k++) begin
            msp_host_model_inst.pins(k[1], k[0]);
            chk(32'(db_oe_ff), 32'(k == 0));
        end
    endtask
    task automatic t_convert();
        logic [17:0] codes [4] = '{18'h1ffff, 18'h00000, 18'h3ffff, 18'h20000};
        logic [17:0] d;
        foreach (codes[i]) begin
            sample_code <= codes[i];
            conv_run();
            chk(n, 65);
            for (int k = 0; k < 4; k++) begin
                msp_host_model_inst.read(k[1], k[0], d);
                chk(32'(d), 32'(lanes(codes[i], k[1], k[0])));
            end
            axi_rd(msp_pkg::OFS_RESULT);
            chk(v, 32'(codes[i]));
        end
    endtask
    task automatic t_auto();
        for (int l = 0; l < 4; l++) begin
            count_sel_high <= l[1];
            count_sel_low <= l[0];
            sequence_reset_pin <= 1'b1;
            msp_host_model_inst.step();
            chk(32'(ch_sel_ff), 32'h0);
            sequence_reset_pin <= 1'b0;
            for (int k = 1; k < 2 * l + 4; k++) begin
                msp_host_model_inst.step();
                chk(32'(ch_sel_ff), 32'(k % (l + 1)));
            end
        end
    endtask
    task automatic t_manual();
        auto_mode <= 1'b0;
        for (int a = 3; a >= 0; a--) begin
            {count_sel_high, count_sel_low} <= 2'(a);
            msp_host_model_inst.step();
            chk(32'(ch_sel_ff), 32'(a));
        end
        auto_mode <= 1'b1;
    endtask
    task automatic t_tied();
        {count_sel_high, count_sel_low, sequence_reset_pin} <= 3'h7;
        msp_host_model_inst.step();
        sequence_reset_pin <= 1'b0;
        msp_host_model_inst.tie_busy = 1'b1;
        conv_run();
        conv_run();
        chk(32'(ch_sel_ff), 32'h2);
        msp_host_model_inst.tie_busy = 1'b0;
    endtask
    task automatic t_irq();
        axi_wr(msp_pkg::OFS_IRQ_STAT, 32'h3);
        axi_wr(msp_pkg::OFS_IRQ_MASK, 32'h1);
        conv_run();
        settle();
        chk(32'(irq_ff), 32'h1);
        axi_rd(msp_pkg::OFS_IRQ_STAT);
        chk(v, 32'h1);
        axi_wr(msp_pkg::OFS_IRQ_STAT, 32'h1);
        settle();
        chk(32'(irq_ff), 32'h0);
        axi_wr(msp_pkg::OFS_IRQ_MASK, 32'h0);
        conv_run();
        settle();
        chk(32'(irq_ff), 32'h0);
        axi_rd(msp_pkg::OFS_IRQ_STAT);
        chk(v, 32'h1);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_bus_float();
        t_convert();
        t_auto();
        t_manual();
        t_tied();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
